// >>> cpsr_map.svh
`ifndef CPSR_MAP_SVH
`define CPSR_MAP_SVH
// core widths
`define CPSR_NUM_REGS 8
`define CPSR_NUM_OUTS 8
`define CPSR_SIG_BITS 160
`define CPSR_SIG_WORDS 5
// register file offsets (word indices)
`define CPSR_ADDR_CONFIG 4'h0
`define CPSR_ADDR_STATUS 4'h1
`define CPSR_ADDR_PRELOAD 4'h2
`define CPSR_ADDR_SLEW 4'h3
`define CPSR_ADDR_READBACK 4'h4
`define CPSR_ADDR_SIG0 4'h8
// config field positions
`define CPSR_CFG_SLEEP_EN 0
`define CPSR_CFG_FUSE 1
// status field positions
`define CPSR_ST_CLEARING 0
`define CPSR_ST_SLEEPING 1
`define CPSR_ST_PRELOAD_OK 2
`define CPSR_ST_REFUSED 3
// reset values
`define CPSR_SLEW_RESET 8'h00
`define CPSR_CONFIG_RESET 2'h0
// power-up clear interval, longest figure in ns, 25 ns clock
`define CPSR_CLEAR_NS 10000
`define CPSR_CLK_NS 25
`define CPSR_CLEAR_CYCLES ((`CPSR_CLEAR_NS + `CPSR_CLK_NS - 1) / `CPSR_CLK_NS)
`endif

// >>> cpsr_pkg.sv
package cpsr_pkg;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    CPSR_CLEAR = 3'h1,
    CPSR_RUN = 3'h2,
    CPSR_SLEEP = 3'h4
  } cpsr_state_t;
endpackage : cpsr_pkg

// >>> cpsr_keeper.sv
`timescale 1ns/1ps
// keeper flop: follows the pin one clock late when open, holds the last level when closed
module cpsr_keeper #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control
  input wire logic hold,
  // data
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] kept
);
  logic [WIDTH-1:0] next_kept; // next held level

  // block the pin while held
  always_comb begin
    next_kept = hold ? kept : pin_in;
  end

  // register the held level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      kept <= '0;
    end else begin
      kept <= next_kept;
    end
  end
endmodule : cpsr_keeper

// >>> cpsr_slew.sv
`timescale 1ns/1ps
// one output pad: holds data and enable, stretches slow edges by one cycle
module cpsr_slew (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // control
  input wire logic freeze,
  input wire logic fast,
  // core side
  input wire logic data_in,
  input wire logic oe_n_in,
  // pad side
  output logic pad_out,
  output logic pad_oe_n
);
  logic stage; // one-cycle delay for slow edges
  logic next_stage;
  logic next_pad_out;
  logic next_pad_oe_n;

  // a slow output sees its data one cycle late, modelling the edge adder
  always_comb begin
    next_stage = freeze ? stage : data_in;
    next_pad_out = freeze ? pad_out : (fast ? data_in : stage);
    next_pad_oe_n = freeze ? pad_oe_n : oe_n_in; // R6
  end

  // register the pad state; outputs come up low and tri-stated
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage <= 1'b0;
      pad_out <= 1'b0;
      pad_oe_n <= 1'b1;
    end else begin
      stage <= next_stage;
      pad_out <= next_pad_out;
      pad_oe_n <= next_pad_oe_n;
    end
  end
endmodule : cpsr_slew

// >>> cpsr_core.sv
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "cpsr_map.svh"
// Functional notes
// R1 - clear every register low at power-up
// R2 - board meets setup before first clock
// R3 - clock sources stable during clear interval
// R4 - optional sleep pin, high enters power-down
// R5 - hold all state and outputs asleep; refused and reg_rdata still move on reads here
// R6 - tri-stated outputs stay tri-stated asleep
// R7 - ignore inputs asleep, keepers hold pins
// R8 - sleep pin not used as logic input
// R9 - each register forcible to one or zero
// R10 - preload entry by elevated pin level
// R11 - per-output slew bit, slow by default
// R12 - fuse blocks readback and preload, not signature
// R13 - fuse programmed as last step
// R14 - sleep pin low resumes from retained state
module cpsr_core (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // sleep request
  input wire logic sleep_request_pin,
  // user logic inputs
  input wire logic [`CPSR_NUM_REGS-1:0] user_in,
  input wire logic [`CPSR_NUM_OUTS-1:0] user_oe_n,
  // preload entry level detected on the designated pin
  input wire logic preload_entry,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // pads
  output logic [`CPSR_NUM_OUTS-1:0] pad_out,
  output logic [`CPSR_NUM_OUTS-1:0] pad_oe_n,
  // status
  output logic sleeping
);
  // state held across sleep: the flops below freeze while hold is high, except refused and reg_rdata, which reads still move
  cpsr_pkg::cpsr_state_t state; // sequencer state
  cpsr_pkg::cpsr_state_t next_state;
  logic [13:0] clear_count; // counts the clear interval
  logic [13:0] next_clear_count;
  logic [1:0] config_bits; // sleep enable and fuse
  logic [1:0] next_config_bits;
  logic [`CPSR_NUM_OUTS-1:0] slew_fast; // 1 = fast edge
  logic [`CPSR_NUM_OUTS-1:0] next_slew_fast;
  logic [`CPSR_NUM_REGS-1:0] macro_regs; // user macrocell registers
  logic [`CPSR_NUM_REGS-1:0] next_macro_regs;
  logic refused; // sticky: a blocked access happened
  logic next_refused;
  logic [31:0] next_reg_rdata;
  logic [`CPSR_NUM_REGS-1:0] kept_in; // inputs after the keepers
  logic [`CPSR_NUM_OUTS-1:0] kept_oe_n;
  logic [`CPSR_SIG_BITS-1:0] signature; // user signature, writable until fused
  logic [`CPSR_SIG_BITS-1:0] next_signature;
  logic hold; // freeze everything but refused and reg_rdata
  logic fuse; // security fuse programmed
  logic preload_ok; // preload allowed now
  logic sig_hit; // address falls in the signature window
  logic [2:0] sig_idx;

  // the fuse is a plain flop here; once set only a reset clears it
  assign fuse = config_bits[`CPSR_CFG_FUSE];
  // the sleep pin only steers the sequencer, never the logic array
  // hold comes from the state flop, not the pin, so a glitch on the
  // pin cannot freeze half of the block for one cycle
  assign hold = (state == cpsr_pkg::CPSR_SLEEP); // R5 R8
  assign sleeping = hold;
  assign preload_ok = preload_entry && !fuse && (state == cpsr_pkg::CPSR_RUN); // R10 R12
  assign sig_hit = (reg_addr >= `CPSR_ADDR_SIG0) && (reg_addr < (`CPSR_ADDR_SIG0 + 4'(`CPSR_SIG_WORDS)));
  assign sig_idx = 3'(reg_addr - `CPSR_ADDR_SIG0);

  // keepers on inputs and enables; closed while asleep
  // every input pays one cycle of latency for this, traded for a clean freeze:
  // nothing that moves on a pin after sleep begins can reach a macrocell
  cpsr_keeper #(.WIDTH(`CPSR_NUM_REGS)) u_keep_in (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .hold(hold),
    .pin_in(user_in),
    .kept(kept_in)
  ); // R7
  cpsr_keeper #(.WIDTH(`CPSR_NUM_OUTS)) u_keep_oe (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .hold(hold),
    .pin_in(user_oe_n),
    .kept(kept_oe_n)
  ); // R7

  // one pad per output, each with its own slew bit
  // a slow pad lags its fast twin by exactly one clock
  genvar gi;
  generate
    for (gi = 0; gi < `CPSR_NUM_OUTS; gi++) begin : g_pad
      cpsr_slew u_slew (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .freeze(hold),
        .fast(slew_fast[gi]),
        .data_in(macro_regs[gi]),
        .oe_n_in(kept_oe_n[gi]),
        .pad_out(pad_out[gi]),
        .pad_oe_n(pad_oe_n[gi])
      ); // R11
    end
  endgenerate

  // sequencer: clear interval, run, sleep
  always_comb begin
    next_state = state;
    next_clear_count = clear_count;
    case (state)
      cpsr_pkg::CPSR_CLEAR: begin
        // hold everything low for the whole interval
        // the count starts at zero, so the last clear cycle is one short of the total
        if (clear_count == 14'(`CPSR_CLEAR_CYCLES - 1)) begin
          next_state = cpsr_pkg::CPSR_RUN; // R1
        end else begin
          next_clear_count = clear_count + 14'h0001;
        end
      end
      cpsr_pkg::CPSR_RUN: begin
        // the pin only counts when the mode is enabled
        // a request while the mode is off is dropped, not remembered
        if (config_bits[`CPSR_CFG_SLEEP_EN] && sleep_request_pin) begin
          next_state = cpsr_pkg::CPSR_SLEEP; // R4
        end
      end
      cpsr_pkg::CPSR_SLEEP: begin
        // wake needs only the pin; configuration cannot change while asleep
        if (!sleep_request_pin) begin
          next_state = cpsr_pkg::CPSR_RUN; // R14
        end
      end
      default: begin
        next_state = cpsr_pkg::CPSR_CLEAR;
      end
    endcase
  end

  // register the sequencer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= cpsr_pkg::CPSR_CLEAR;
      clear_count <= 14'h0000;
    end else begin
      state <= next_state;
      clear_count <= next_clear_count;
    end
  end

  // macrocells, configuration and register port
  // writes are dropped while asleep, reads still answer so software can
  // see the sleeping flag; a refused preload or blocked readback only marks the sticky flag
  always_comb begin
    next_macro_regs = macro_regs;
    next_config_bits = config_bits;
    next_slew_fast = slew_fast;
    next_refused = refused;
    next_signature = signature;
    next_reg_rdata = 32'h0000_0000;
    if (state == cpsr_pkg::CPSR_RUN) begin
      // normal operation: registers capture the kept inputs
      next_macro_regs = kept_in;
    end
    // asleep, writes are dropped: registers and config are frozen
    if (reg_write && !hold) begin
      case (reg_addr)
        `CPSR_ADDR_CONFIG: begin
          // the fuse can be set but never cleared
          next_config_bits[`CPSR_CFG_SLEEP_EN] = reg_wdata[`CPSR_CFG_SLEEP_EN];
          next_config_bits[`CPSR_CFG_FUSE] = fuse | reg_wdata[`CPSR_CFG_FUSE]; // R13
        end
        `CPSR_ADDR_SLEW: begin
          // one bit per pad; zero keeps the slow default
          next_slew_fast = reg_wdata[`CPSR_NUM_OUTS-1:0]; // R11
        end
        `CPSR_ADDR_PRELOAD: begin
          // without the entry level, after fusing or during the clear interval the write is refused
          if (preload_ok) begin
            // preload wins over the normal capture
            next_macro_regs = reg_wdata[`CPSR_NUM_REGS-1:0]; // R9
          end else begin
            next_refused = 1'b1; // R12
          end
        end
        default: begin
          // signature words can be rewritten until the fuse is set
          if (sig_hit && !fuse) begin
            next_signature[sig_idx*32 +: 32] = reg_wdata;
          end
        end
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        `CPSR_ADDR_CONFIG: next_reg_rdata = {30'h0, config_bits};
        `CPSR_ADDR_STATUS: begin
          next_reg_rdata = {28'h0, refused, preload_ok, hold, state == cpsr_pkg::CPSR_CLEAR};
          // clears on read; a refusal only comes through this port, and the
          // port carries one address per cycle, so a set never meets this clear
          next_refused = 1'b0;
        end
        `CPSR_ADDR_SLEW: next_reg_rdata = {24'h0, slew_fast};
        `CPSR_ADDR_READBACK: begin
          // the refused flag is the only trace of a blocked readback
          if (fuse) begin
            next_refused = 1'b1; // R12
          end else begin
            next_reg_rdata = {24'h0, macro_regs};
          end
        end
        default: begin
          if (sig_hit) begin
            // signature stays readable after fusing
            next_reg_rdata = signature[sig_idx*32 +: 32]; // R12
          end
        end
      endcase
    end
  end

  // register file; everything comes up low
  // the signature lives in flops here, so it resets with everything else
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      macro_regs <= '0; // R1
      config_bits <= `CPSR_CONFIG_RESET;
      slew_fast <= `CPSR_SLEW_RESET; // R11
      refused <= 1'b0;
      signature <= '0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      macro_regs <= next_macro_regs;
      config_bits <= next_config_bits;
      slew_fast <= next_slew_fast;
      refused <= next_refused;
      signature <= next_signature;
      reg_rdata <= next_reg_rdata;
    end
  end

  // the checks below watch only what this block drives; the sleep pin and
  // the register port are stimulus and appear in antecedents only, save reg_wdata in a_preload_set

  // registers stay low through the clear interval
  a_clear_low: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
    (state == cpsr_pkg::CPSR_CLEAR) |-> (macro_regs == '0)) else $error("register moved during clear");
  // the clear interval ends on its last count
  a_clear_end: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
    (state == cpsr_pkg::CPSR_CLEAR && clear_count == 14'(`CPSR_CLEAR_CYCLES - 1))
    |=> (state == cpsr_pkg::CPSR_RUN)) else $error("clear did not end");
  // and not one cycle earlier
  a_clear_stay: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
    (state == cpsr_pkg::CPSR_CLEAR && clear_count != 14'(`CPSR_CLEAR_CYCLES - 1))
    |=> (state == cpsr_pkg::CPSR_CLEAR)) else $error("clear ended early");
  // sleep entry one cycle after enabled request
  a_sleep_entry: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
    (state == cpsr_pkg::CPSR_RUN && config_bits[`CPSR_CFG_SLEEP_EN] && sleep_request_pin) |=> hold)
    else $error("no sleep");
  // disabled mode never sleeps
  a_sleep_gated: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
    (state == cpsr_pkg::CPSR_RUN && !config_bits[`CPSR_CFG_SLEEP_EN]) |=> !hold)
    else $error("slept while disabled");
  // the status word reports the sleeping flag
  a_status_sleep: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
    (reg_read && reg_addr == `CPSR_ADDR_STATUS) |=> (reg_rdata[`CPSR_ST_SLEEPING] == $past(hold)))
    else $error("status sleep flag wrong");
  // state frozen while asleep
  a_hold_state: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
    (hold && $past(hold)) |-> $stable(macro_regs) && $stable(pad_out)) else $error("state moved asleep");
  // enables frozen while asleep
  a_hold_oe: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
    (hold && $past(hold)) |-> $stable(pad_oe_n)) else $error("enable moved asleep");
  // input keeper closed asleep
  a_keep_in: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
    (hold && $past(hold)) |-> $stable(kept_in)) else $error("input passed asleep");
  // writes are dropped while asleep
  a_sleep_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
    (hold && reg_write) |=> $stable(config_bits) && $stable(slew_fast) && $stable(signature))
    else $error("write landed asleep");
  // preload forces the value
  a_preload_set: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9
    (reg_write && reg_addr == `CPSR_ADDR_PRELOAD && preload_ok) |=> macro_regs == $past(reg_wdata[7:0]))
    else $error("preload");
  // a fused preload is refused and flagged
  a_fused_preload: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
    (reg_write && !hold && reg_addr == `CPSR_ADDR_PRELOAD && fuse) |=> refused)
    else $error("fused preload not flagged");
  // fused readback returns zero
  a_fuse_read: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
    (reg_read && reg_addr == `CPSR_ADDR_READBACK && fuse) |=> reg_rdata == 32'h0) else $error("readback leaked");
  // the fuse never clears once set
  a_fuse_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12
    fuse |=> fuse) else $error("fuse cleared");
  // wake within one cycle of pin low
  a_wake: assert property (@(posedge sys_clk) disable iff (!reset_n) // R14
    (hold && !sleep_request_pin) |=> !hold) else $error("no wake");
  // waking resumes from the retained registers
  a_wake_resume: assert property (@(posedge sys_clk) disable iff (!reset_n) // R14
    (hold && !sleep_request_pin) |=> $stable(macro_regs)) else $error("registers lost on wake");
endmodule : cpsr_core

// >>> cpsr_board.sv
`timescale 1ns/1ps
`include "cpsr_map.svh"
// board model: turns bench commands into pin levels, one clock after each command
module cpsr_board (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // commands from the bench
  input wire logic [`CPSR_NUM_REGS-1:0] want_in,
  input wire logic [`CPSR_NUM_OUTS-1:0] want_oe_n,
  input wire logic want_sleep,
  input wire logic want_preload,
  // pins toward the block
  output logic [`CPSR_NUM_REGS-1:0] user_in,
  output logic [`CPSR_NUM_OUTS-1:0] user_oe_n,
  output logic sleep_request_pin,
  output logic preload_entry
);
  // pins move only on clock edges and sit at fixed levels while reset holds,
  // so nothing feeding the clock path wobbles during the clear interval
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      user_in <= 8'hFF;
      user_oe_n <= 8'h00;
      sleep_request_pin <= 1'b0;
      preload_entry <= 1'b0;
    end else begin
      user_in <= want_in;
      user_oe_n <= want_oe_n;
      // the sleep pin has its own wire and never joins the logic inputs
      sleep_request_pin <= want_sleep;
      // elevated level on the preload pin, stated as a plain level here
      preload_entry <= want_preload;
    end
  end
endmodule : cpsr_board

// >>> test_cpsr_core.sv
`timescale 1ns/1ps
`include "cpsr_map.svh"
module test_cpsr_core;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  // bench commands to the board
  logic [7:0] want_in = 8'hFF;
  logic [7:0] want_oe_n = 8'h00;
  logic want_sleep = 1'b0;
  logic want_preload = 1'b0;
  // register port
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  // pins
  logic [7:0] user_in, user_oe_n, pad_out, pad_oe_n;
  logic sleep_request_pin, preload_entry, sleeping;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] d;
  int ns, nf;
  always #12.5 sys_clk = ~sys_clk;
  cpsr_board BOARD (.sys_clk(sys_clk), .reset_n(reset_n), .want_in(want_in), .want_oe_n(want_oe_n),
    .want_sleep(want_sleep), .want_preload(want_preload), .user_in(user_in), .user_oe_n(user_oe_n),
    .sleep_request_pin(sleep_request_pin), .preload_entry(preload_entry));
  cpsr_core DUT (.sys_clk(sys_clk), .reset_n(reset_n), .sleep_request_pin(sleep_request_pin),
    .user_in(user_in), .user_oe_n(user_oe_n), .preload_entry(preload_entry), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .sleeping(sleeping));
  // one comparison kind: four-state values, so an unknown never matches
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task give_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // the whole run needs about 600 cycles, so this ceiling only trips on a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end
  task wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wait_n
  // one-cycle write strobe
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // pins high during the clear, yet the registered pads must stay low
  task t_clear;
    // reset_n starts low with no edge, so the flops only clear on the first clock
    repeat (3) @(posedge sys_clk);
    chk({15'h0, sleeping, pad_out, pad_oe_n}, 32'h000000FF, "reset pads");
    reset_n <= 1'b1;
    wait_n(200);
    chk(pad_out, 32'h0, "pads low in clear");
    rd(`CPSR_ADDR_STATUS, d);
    chk(d[0], 32'h1, "clearing flag");
    wait_n(250);
    rd(`CPSR_ADDR_STATUS, d);
    chk(d[0], 32'h0, "clear ends");
    chk({pad_out, pad_oe_n}, 32'hFF00, "pads follow after clear");
    rd(`CPSR_ADDR_SLEW, d);
    chk(d, 32'h0, "slew reset slow");
    rd(`CPSR_ADDR_CONFIG, d);
    chk(d, 32'h0, "config reset");
    rd(4'hF, d);
    chk(d, 32'h0, "unmapped read");
  endtask : t_clear
  // cycles from an input change until the pads show it
  task lat(input logic [31:0] s, output int n);
    logic [7:0] t;
    wr(`CPSR_ADDR_SLEW, s);
    wait_n(4);
    t = ~want_in;
    want_in <= t;
    n = 0;
    while (pad_out !== t && n < 20) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask : lat
  task t_slew;
    lat(32'h0, ns);
    lat(32'hFF, nf);
    chk(32'(ns), 32'(nf + 1), "slow adds one cycle");
  endtask : t_slew
  // refusal without the entry level, sticky flag cleared by the read
  task t_refuse;
    wr(`CPSR_ADDR_PRELOAD, 32'hA5);
    rd(`CPSR_ADDR_STATUS, d);
    chk(d[3], 32'h1, "preload refused");
    rd(`CPSR_ADDR_STATUS, d);
    chk(d[3], 32'h0, "refused clears");
    want_preload <= 1'b1;
    wait_n(2);
    wr(`CPSR_ADDR_PRELOAD, 32'h5A);
    // the forced value shows on the fast pads one clock later, then capture resumes
    @(posedge sys_clk);
    #1 chk(pad_out, 32'h5A, "preload on pads");
    rd(`CPSR_ADDR_STATUS, d);
    chk(d[3], 32'h0, "preload taken");
    chk(d[2], 32'h1, "preload allowed");
  endtask : t_refuse
  task t_sleep;
    // pin is ignored while the mode is off
    want_sleep <= 1'b1;
    wait_n(4);
    chk(sleeping, 32'h0, "sleep off");
    want_sleep <= 1'b0;
    wr(`CPSR_ADDR_CONFIG, 32'h1);
    want_in <= 8'h3C;
    want_oe_n <= 8'h0F;
    wait_n(6);
    want_sleep <= 1'b1;
    wait_n(4);
    chk(sleeping, 32'h1, "asleep");
    // inputs, enables and writes all move while asleep; nothing may follow
    want_in <= 8'hC3;
    want_oe_n <= 8'h00;
    wr(`CPSR_ADDR_SLEW, 32'h0);
    wait_n(4);
    chk({pad_out, pad_oe_n}, 32'h3C0F, "pads held");
    rd(`CPSR_ADDR_STATUS, d);
    chk(d[1], 32'h1, "status asleep");
    want_sleep <= 1'b0;
    wait_n(8);
    chk({15'h0, sleeping, pad_out, pad_oe_n}, 32'hC300, "woken");
    rd(`CPSR_ADDR_SLEW, d);
    chk(d, 32'hFF, "write ignored asleep");
  endtask : t_sleep
  // fuse set as the final step, since it bites at once
  task t_fuse;
    wr(`CPSR_ADDR_SIG0, 32'h1234ABCD);
    rd(`CPSR_ADDR_READBACK, d);
    chk(d, 32'hC3, "readback open");
    wr(`CPSR_ADDR_CONFIG, 32'h2);
    rd(`CPSR_ADDR_READBACK, d);
    chk(d, 32'h0, "readback blocked");
    rd(`CPSR_ADDR_STATUS, d);
    chk(d[3], 32'h1, "readback refused");
    wr(`CPSR_ADDR_PRELOAD, 32'h77);
    @(posedge sys_clk);
    #1 chk(pad_out, 32'hC3, "fused preload blocked");
    rd(`CPSR_ADDR_STATUS, d);
    chk(d[3], 32'h1, "preload refused fused");
    rd(`CPSR_ADDR_SIG0, d);
    chk(d, 32'h1234ABCD, "signature readable");
  endtask : t_fuse
  initial begin
    t_clear;
    t_slew;
    t_refuse;
    t_sleep;
    t_fuse;
    give_verdict;
  end
endmodule : test_cpsr_core
